// ### host_model.sv
module host_model
  import lcd_host_port_pkg::*;
(
  // Clock and device outputs
  input wire logic clock,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe_n,
  input wire logic serialDataOut,
  input wire logic serialDataOe_n,
  // Host pins
  output logic port_select_bit_first,
  output logic port_select_bit_second,
  output logic port_select_bit_third,
  output logic slave_addr_select_lo,
  output logic slave_addr_select_hi,
  output logic chip_select_n,
  output logic cmd_data_select,
  output logic readStrobe,
  output logic writeStrobe,
  output logic [7:0] hostDataIn,
  output logic serialClock,
  output logic serialDataIn
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] modeNow;
  logic sdaDrv;
  logic busDrive;
  logic [7:0] busVal;

  assign {port_select_bit_first, port_select_bit_second,
          port_select_bit_third} = modeNow;
  // A released bus shows the inverse of the last value, never a held copy.
  assign hostDataIn = !hostDataOe_n ? hostDataOut
                      : (busDrive ? busVal : ~busVal);
  // The two-wire line is open drain with a pull-up; SPI lines are shorted.
  assign serialDataIn = serialDataOe_n ? sdaDrv
                        : (modeNow == MODE_I2C ? sdaDrv & serialDataOut
                           : serialDataOut);

  initial
  begin
    modeNow = MODE_SPI4;
    {slave_addr_select_hi, slave_addr_select_lo} = 2'h0;
    {chip_select_n, cmd_data_select, readStrobe, writeStrobe} = 4'hF;
    {serialClock, sdaDrv, busDrive} = 3'h6;
    busVal = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic set_mode(input logic [2:0] m, input logic [1:0] sa);
    chip_select_n <= 1'b1;
    modeNow <= m;
    {slave_addr_select_hi, slave_addr_select_lo} <= sa;
    readStrobe <= m != MODE_PENA;
    {writeStrobe, serialClock, sdaDrv} <= 3'h7;
    hold(8);
  endtask

  // Data moves only while the clock is low.
  task automatic clk_bit(input logic b, input int half);
    serialClock <= 1'b0;
    hold(2);
    sdaDrv <= b;
    hold(half - 2);
    serialClock <= 1'b1;
    hold(half);
  endtask

  task automatic spi_byte(input logic cds, input logic flag,
                          input logic [7:0] b, input int half);
    chip_select_n <= 1'b0;
    cmd_data_select <= cds;
    hold(4);
    if (modeNow == MODE_SPI3)
      clk_bit(flag, half);
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], half);
  endtask

  // Slow clock so the leading status bits are valid.
  task automatic read_back(output logic [7:0] v, output logic gone);
    sdaDrv <= 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      serialClock <= 1'b0;
      hold(24);
      @(negedge clock);
      v[i] = serialDataOe_n ? 1'bx : serialDataOut;
      @(posedge clock);
      serialClock <= 1'b1;
      hold(24);
    end
    serialClock <= 1'b0;
    hold(24);
    @(negedge clock);
    gone = serialDataOe_n;
    @(posedge clock);
    chip_select_n <= 1'b1;
    hold(4);
    serialClock <= 1'b1;
    hold(4);
  endtask

  task automatic par_xfer(input logic sel, input logic cds, input logic rd,
      input logic [7:0] wd, output logic [7:0] rdv, output logic drove);
    chip_select_n <= !sel;
    cmd_data_select <= cds;
    busDrive <= !rd;
    busVal <= wd;
    if (modeNow == MODE_PENA)
      writeStrobe <= rd;
    hold(3);
    if (modeNow == MODE_PENA)
      readStrobe <= 1'b1;
    else if (rd)
      readStrobe <= 1'b0;
    else
      writeStrobe <= 1'b0;
    hold(6);
    @(negedge clock);
    rdv = hostDataOut;
    drove = !hostDataOe_n;
    @(posedge clock);
    if (modeNow == MODE_PENA)
      readStrobe <= 1'b0;
    else
      {readStrobe, writeStrobe} <= 2'h3;
    hold(3);
    chip_select_n <= 1'b1;
    busDrive <= 1'b0;
    hold(4);
  endtask

  // Enable tied high: the select pulse itself frames the write.
  task automatic cs_enable_write(input logic cds, input logic [7:0] wd);
    {readStrobe, writeStrobe} <= 2'h2;
    cmd_data_select <= cds;
    busDrive <= 1'b1;
    busVal <= wd;
    hold(3);
    chip_select_n <= 1'b0;
    hold(6);
    chip_select_n <= 1'b1;
    hold(4);
    readStrobe <= 1'b0;
    busDrive <= 1'b0;
    hold(4);
  endtask

  // Begins only from the idle bus, both lines high.
  task automatic i2c_start();
    sdaDrv <= 1'b0;
    hold(4);
  endtask

  task automatic i2c_stop();
    serialClock <= 1'b0;
    hold(2);
    sdaDrv <= 1'b0;
    hold(2);
    serialClock <= 1'b1;
    hold(4);
    sdaDrv <= 1'b1;
    hold(4);
  endtask

  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], 4);
    serialClock <= 1'b0;
    hold(2);
    sdaDrv <= 1'b1;
    hold(2);
    serialClock <= 1'b1;
    hold(2);
    @(negedge clock);
    ack = !serialDataOe_n && !serialDataOut;
    @(posedge clock);
    hold(1);
  endtask
endmodule

// ### lcd_host_port.sv
// Operation
// - Deselected: strobes ignored, data bus released.
// - Serial mode deselected clears shift register and bit counter.
// - Three mode pins pick 4-wire, 3-wire, strobe bus, enable bus or I2C.
// - Parallel modes use 8-bit two-way bus; third pin picks bus style.
// - Select plus direction: data read/write, status read, instruction write.
// - Enable held high: chip select rising edge ends the transfer.
// - 4-wire: select low enables input, select pin marks data or command.
// - Without select pin bytes are commands until a byte count is loaded.
// - Bits taken on serial clock rise, MSB first, byte on eighth.
// - Each display data byte advances the column pointer by one.
// - After the announced data bytes, serial bytes are commands again.
// - Readback drives status on four edges, then its complement on four.
// - After eighth bit, readback ends at falling edge of eighth clock.
// - Two-wire data stays stable while clock high, one bit per pulse.
// - START is data falling with clock high; STOP is data rising.
// - Two-wire command bytes executed, data bytes sent to display RAM.
// - Answer only addresses 0111100 to 0111111 set by two pins.
// - Control bytes carry continuation flag and select; flag clear ends them.
// - Acknowledge each byte by holding data low through ninth pulse.
// - First display read after address set returns stale holder content.
module lcd_host_port
  import lcd_host_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Port selection and slave address pins
  input wire logic port_select_bit_first,
  input wire logic port_select_bit_second,
  input wire logic port_select_bit_third,
  input wire logic slave_addr_select_lo,
  input wire logic slave_addr_select_hi,
  // Parallel host pins
  input wire logic chip_select_n,
  input wire logic cmd_data_select,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe_n,
  // Serial host pins, shared by the SPI and two-wire ports
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe_n,
  // Core side
  input wire logic selfTestStatus,
  input wire logic [7:0] statusByte,
  input wire logic [7:0] ramReadData,
  input wire logic dataCountLoad,
  input wire logic [7:0] dataCountValue,
  output logic [7:0] rxByte,
  output logic cmdStrobe,
  output logic dataStrobe,
  output logic columnAdvance,
  output logic ramReadStrobe,
  output logic statusReadStrobe
);

  function automatic port_mode_t portMode(input logic [2:0] ps);
    case (ps)
      3'b000: portMode = MODE_SPI4;
      3'b001: portMode = MODE_SPI3;
      3'b010: portMode = MODE_PSTB;
      3'b011: portMode = MODE_PENA;
      3'b111: portMode = MODE_I2C;
      default: portMode = MODE_NONE;
    endcase
  endfunction

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [7:0] spiShift;
    logic [2:0] spiCnt;
    logic flagSeen;
    logic flag;
    logic spiHold;
    logic [7:0] dataLeft;
    logic rbActive;
    logic [3:0] rbCnt;
    logic rbStatus;
    tw_state_t twState;
    logic [7:0] twShift;
    logic [2:0] twCnt;
    logic byteDone;
    logic ackPhase;
    logic ackDrive;
    logic contFlag;
    logic dataSel;
    logic parActive;
    logic parRead;
    logic parCds;
    logic [7:0] parData;
    logic [7:0] outReg;
    logic [7:0] holder;
    logic [7:0] rxByte;
    logic cmdStb;
    logic dataStb;
    logic colInc;
    logic ramRd;
    logic statusRd;
  } state_t;

  state_t q;
  state_t d;
  port_mode_t mode;
  logic [PIN_W-1:0] pinsNow;
  logic csN;
  logic sck;
  logic sckRise;
  logic sckFall;
  logic sdiRise;
  logic sdiFall;
  logic twStart;
  logic twStop;
  logic serialMode;
  logic spiByte;
  logic byteIsData;
  logic enable;
  logic readDir;
  logic [7:0] newByte;
  logic addrMatch;

  assign pinsNow = {port_select_bit_first, port_select_bit_second,
                    port_select_bit_third, slave_addr_select_hi,
                    slave_addr_select_lo, chip_select_n, cmd_data_select,
                    readStrobe, writeStrobe, serialClock, serialDataIn,
                    hostDataIn};

  always_comb
  begin
    d = q;
    d.s1 = pinsNow;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.cmdStb = 1'b0;
    d.dataStb = 1'b0;
    d.colInc = 1'b0;
    d.ramRd = 1'b0;
    d.statusRd = 1'b0;
    mode = portMode(q.s2[PIN_PS_MSB:PIN_PS_LSB]);
    csN = q.s2[PIN_CSN];
    sck = q.s2[PIN_SCK];
    sckRise = sck & ~q.s3[PIN_SCK];
    sckFall = ~sck & q.s3[PIN_SCK];
    sdiRise = q.s2[PIN_SDI] & ~q.s3[PIN_SDI];
    sdiFall = ~q.s2[PIN_SDI] & q.s3[PIN_SDI];
    twStart = sck & q.s3[PIN_SCK] & sdiFall;
    twStop = sck & q.s3[PIN_SCK] & sdiRise;
    serialMode = (mode == MODE_SPI4) || (mode == MODE_SPI3);
    spiByte = 1'b0;
    byteIsData = 1'b0;
    enable = 1'b0;
    readDir = 1'b0;
    newByte = {q.spiShift[6:0], q.s2[PIN_SDI]};
    addrMatch = 1'b0;

    // Serial ports. A byte is only ever taken on a synchronised clock rise.
    if (!serialMode || csN)
    begin
      d.spiShift = BYTE_RESET;
      d.spiCnt = 3'h0;
      d.flagSeen = 1'b0;
      d.spiHold = 1'b0;
      d.rbActive = 1'b0;
      d.rbCnt = 4'h0;
    end
    else if (q.rbActive)
    begin
      if (sckRise && q.rbCnt != RB_LEN)
        d.rbCnt = q.rbCnt + 4'h1;
      if (sckFall && q.rbCnt == RB_LEN)
      begin
        d.rbActive = 1'b0;
        d.spiHold = 1'b1;
      end
    end
    else if (!q.spiHold && sckRise)
    begin
      if (mode == MODE_SPI3 && !q.flagSeen)
      begin
        d.flagSeen = 1'b1;
        d.flag = q.s2[PIN_SDI];
      end
      else
      begin
        d.spiShift = newByte;
        d.spiCnt = q.spiCnt + 3'h1;
        spiByte = (q.spiCnt == LAST_BIT);
      end
    end
    if (spiByte)
    begin
      d.flagSeen = 1'b0;
      d.rxByte = newByte;
      if (mode == MODE_SPI4)
        byteIsData = q.s2[PIN_CDS];
      else
        byteIsData = (q.dataLeft != COUNT_RESET);
      d.dataStb = byteIsData;
      d.colInc = byteIsData;
      d.cmdStb = ~byteIsData;
      if (mode == MODE_SPI3 && byteIsData)
        d.dataLeft = q.dataLeft - 8'h01;
      if (mode == MODE_SPI3 && !byteIsData && !q.flag &&
          newByte == SELF_TEST_CMD)
      begin
        d.rbActive = 1'b1;
        d.rbCnt = 4'h0;
        d.rbStatus = selfTestStatus;
      end
    end
    // The decoder announces the byte count after the direction command.
    if (dataCountLoad)
      d.dataLeft = dataCountValue;

    // Two-wire slave receiver.
    if (mode != MODE_I2C || twStop)
    begin
      d.twState = TW_IDLE;
      d.byteDone = 1'b0;
      d.ackPhase = 1'b0;
      d.ackDrive = 1'b0;
    end
    else if (twStart)
    begin
      d.twState = TW_ADDR;
      d.twCnt = 3'h0;
      d.byteDone = 1'b0;
      d.ackPhase = 1'b0;
      d.ackDrive = 1'b0;
    end
    else if (q.twState != TW_IDLE)
    begin
      if (sckRise && !q.ackPhase && !q.byteDone)
      begin
        newByte = {q.twShift[6:0], q.s2[PIN_SDI]};
        d.twShift = newByte;
        d.twCnt = q.twCnt + 3'h1;
        if (q.twCnt == LAST_BIT)
        begin
          d.byteDone = 1'b1;
          case (q.twState)
            TW_ADDR:
            begin
              addrMatch = newByte[7:3] == I2C_ADDR_BASE &&
                newByte[2:1] == {q.s2[PIN_ADDR_HI], q.s2[PIN_ADDR_LO]} &&
                !newByte[0];
              d.twState = addrMatch ? TW_CTRL : TW_SKIP;
            end
            TW_CTRL:
            begin
              d.contFlag = newByte[7];
              d.dataSel = newByte[6];
              d.twState = TW_DATA;
            end
            TW_DATA:
            begin
              d.rxByte = newByte;
              d.dataStb = q.dataSel;
              d.colInc = q.dataSel;
              d.cmdStb = ~q.dataSel;
              d.twState = q.contFlag ? TW_CTRL : TW_DATA;
            end
            default: d.twState = q.twState;
          endcase
        end
      end
      if (sckFall && q.byteDone)
      begin
        d.byteDone = 1'b0;
        d.ackPhase = 1'b1;
        d.ackDrive = (q.twState != TW_SKIP);
      end
      else if (sckFall && q.ackPhase)
      begin
        d.ackPhase = 1'b0;
        d.ackDrive = 1'b0;
      end
    end

    // Parallel ports. One transfer per active window; reads taken at its start, writes on its end.
    if (mode == MODE_PENA)
    begin
      enable = ~csN & q.s2[PIN_RD];
      readDir = q.s2[PIN_WR];
    end
    else if (mode == MODE_PSTB)
    begin
      enable = ~csN & (~q.s2[PIN_RD] | ~q.s2[PIN_WR]);
      readDir = ~q.s2[PIN_RD];
    end
    if (enable && !q.parActive)
    begin
      d.parActive = 1'b1;
      d.parRead = readDir;
      d.parCds = q.s2[PIN_CDS];
      if (readDir && q.s2[PIN_CDS])
      begin
        d.outReg = q.holder;
        d.holder = ramReadData;
        d.ramRd = 1'b1;
        d.colInc = 1'b1;
      end
      else if (readDir)
      begin
        d.outReg = statusByte;
        d.statusRd = 1'b1;
      end
    end
    if (enable)
      d.parData = q.s2[PIN_DATA_MSB:PIN_DATA_LSB];
    if (!enable && q.parActive)
    begin
      d.parActive = 1'b0;
      if (!q.parRead)
      begin
        d.rxByte = q.parData;
        d.dataStb = q.parCds;
        d.colInc = q.parCds;
        d.cmdStb = ~q.parCds;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.s1 <= {PIN_W{1'b1}};
      q.s2 <= {PIN_W{1'b1}};
      q.s3 <= {PIN_W{1'b1}};
    end
    else
      q <= d;
  end

  // The bus is only driven while a read window is open and selected.
  assign hostDataOut = q.outReg;
  assign hostDataOe_n = ~(q.parActive & q.parRead);
  assign serialDataOut = q.ackDrive ? 1'b0 :
    ((q.rbCnt < RB_HALF) ? q.rbStatus : ~q.rbStatus);
  assign serialDataOe_n = ~(q.rbActive | q.ackDrive);
  assign rxByte = q.rxByte;
  assign cmdStrobe = q.cmdStb;
  assign dataStrobe = q.dataStb;
  assign columnAdvance = q.colInc;
  assign ramReadStrobe = q.ramRd;
  assign statusReadStrobe = q.statusRd;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  deselect_hiz_a:
    assert property (q.s2[PIN_CSN] [*2] |-> hostDataOe_n)
    else $error("Data bus driven while deselected.");
  serial_clear_a:
    assert property (serialMode && csN |=> q.spiShift == 8'h00 &&
      q.spiCnt == 3'h0)
    else $error("Serial state not cleared on deselect.");
  tw_mode_a:
    assert property (mode != MODE_I2C |=> q.twState == TW_IDLE)
    else $error("Two-wire receiver active outside its mode.");
  par_write_a:
    assert property (q.parActive && !enable && !q.parRead |=>
      q.rxByte == $past(q.parData) && (q.dataStb == $past(q.parCds)) &&
      (q.cmdStb != $past(q.parCds)))
    else $error("Parallel write not delivered once.");
  spi_byte_a:
    assert property (spiByte |=> (q.cmdStb ^ q.dataStb) &&
      q.rxByte == $past(newByte))
    else $error("Serial byte not delivered on eighth clock.");
  column_step_a:
    assert property (q.dataStb |-> q.colInc)
    else $error("Data byte without column advance.");
  count_end_a:
    assert property (spiByte && mode == MODE_SPI3 &&
      q.dataLeft == 8'h00 |=> q.cmdStb)
    else $error("Byte after data string not taken as command.");
  readback_bits_a:
    assert property ($rose(q.rbActive) |-> !serialDataOe_n &&
      serialDataOut == q.rbStatus)
    else $error("Readback did not start with the status bit.");
  readback_end_a:
    assert property (q.rbActive && q.rbCnt == RB_LEN && sckFall && !csN
      |=> !q.rbActive && q.spiHold && serialDataOe_n)
    else $error("Readback not released at eighth falling edge.");
  tw_start_a:
    assert property (mode == MODE_I2C && twStart && !twStop |=>
      q.twState == TW_ADDR && q.twCnt == 3'h0)
    else $error("START not detected.");
  ack_hold_a:
    assert property (q.ackDrive && !sckFall && !twStart && !twStop &&
      mode == MODE_I2C |=> q.ackDrive)
    else $error("Acknowledge dropped before clock fell.");
  dummy_read_a:
    assert property (q.ramRd |-> q.outReg == $past(q.holder))
    else $error("Display read did not return the holder.");

  cover_readback_c: cover property (q.rbActive ##1 !q.rbActive);
  cover_tw_data_c: cover property (q.twState == TW_DATA && q.dataStb);
  cover_par_read_c: cover property (q.ramRd ##[1:20] !hostDataOe_n);
  cover_spi4_c: cover property (spiByte && mode == MODE_SPI4);

endmodule

// ### lcd_host_port_pkg.sv
package lcd_host_port_pkg;

  // Bit positions inside the synchronised host pin vector.
  localparam int PIN_W = 19;
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_DATA_MSB = 7;
  localparam int PIN_SDI = 8;
  localparam int PIN_SCK = 9;
  localparam int PIN_WR = 10;
  localparam int PIN_RD = 11;
  localparam int PIN_CDS = 12;
  localparam int PIN_CSN = 13;
  localparam int PIN_ADDR_LO = 14;
  localparam int PIN_ADDR_HI = 15;
  localparam int PIN_PS_LSB = 16;
  localparam int PIN_PS_MSB = 18;

  // Upper five bits of the 7-bit two-wire slave address.
  localparam logic [4:0] I2C_ADDR_BASE = 5'h0F;
  // Command that opens the three-wire status readback.
  localparam logic [7:0] SELF_TEST_CMD = 8'hDB;

  // Readback length and the point where the complement starts.
  localparam logic [3:0] RB_HALF = 4'h4;
  localparam logic [3:0] RB_LEN = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Reset values.
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // Host port selected by the three mode pins, first pin as MSB.
  typedef enum logic [2:0] {
    MODE_SPI4 = 3'b000,
    MODE_SPI3 = 3'b001,
    MODE_PSTB = 3'b010,
    MODE_PENA = 3'b011,
    MODE_I2C = 3'b111,
    MODE_NONE = 3'b100
  } port_mode_t;

  // Two-wire receiver states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_CTRL = 3'b011,
    TW_DATA = 3'b010,
    TW_SKIP = 3'b110
  } tw_state_t;

endpackage

// ### testbench.sv
module testbench
  import lcd_host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock, rst_n, selfTestStatus, dataCountLoad, cmdStrobe, dataStrobe;
  logic [7:0] statusByte, ramReadData, dataCountValue, rxByte, lastByte;
  logic port_select_bit_first, port_select_bit_second, port_select_bit_third;
  logic slave_addr_select_lo, slave_addr_select_hi, chip_select_n;
  logic cmd_data_select, readStrobe, writeStrobe, serialClock;
  logic serialDataIn, serialDataOut, serialDataOe_n, hostDataOe_n;
  logic [7:0] hostDataIn, hostDataOut;
  logic columnAdvance, ramReadStrobe, statusReadStrobe;
  int nFail, totalChecks, cycles, nCmd, nData, nCol, nRam, nStat;
  int bCmd, bData, bCol;

  lcd_host_port dut (
    .clock, .rst_n, .port_select_bit_first, .port_select_bit_second,
    .port_select_bit_third, .slave_addr_select_lo, .slave_addr_select_hi,
    .chip_select_n, .cmd_data_select, .readStrobe, .writeStrobe,
    .hostDataIn, .hostDataOut, .hostDataOe_n, .serialClock, .serialDataIn,
    .serialDataOut, .serialDataOe_n, .selfTestStatus, .statusByte,
    .ramReadData, .dataCountLoad, .dataCountValue, .rxByte, .cmdStrobe,
    .dataStrobe, .columnAdvance, .ramReadStrobe, .statusReadStrobe
  );

  host_model host (
    .clock, .hostDataOut, .hostDataOe_n, .serialDataOut, .serialDataOe_n,
    .port_select_bit_first, .port_select_bit_second, .port_select_bit_third,
    .slave_addr_select_lo, .slave_addr_select_hi, .chip_select_n,
    .cmd_data_select, .readStrobe, .writeStrobe, .hostDataIn, .serialClock,
    .serialDataIn
  );

  always @(posedge clock)
  begin
    nCmd <= nCmd + int'(cmdStrobe === 1'b1);
    nData <= nData + int'(dataStrobe === 1'b1);
    nCol <= nCol + int'(columnAdvance === 1'b1);
    nRam <= nRam + int'(ramReadStrobe === 1'b1);
    nStat <= nStat + int'(statusReadStrobe === 1'b1);
    if (cmdStrobe === 1'b1 || dataStrobe === 1'b1)
      lastByte <= rxByte;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      nFail++;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic mark();
    bCmd = nCmd;
    bData = nData;
    bCol = nCol;
  endtask

  // Strobes land 3 to 4 clocks after the closing pin edge.
  task automatic expect_rx(input string what, input int dc, input int dd,
                           input logic [7:0] b);
    repeat (6) @(posedge clock);
    @(negedge clock);
    check({what, " cmd"}, 8'(nCmd - bCmd), 8'(dc));
    check({what, " data"}, 8'(nData - bData), 8'(dd));
    check({what, " column"}, 8'(nCol - bCol), 8'(dd));
    if (dc + dd > 0)
      check({what, " byte"}, lastByte, b);
    mark();
  endtask

  task automatic spi4Test();
    host.set_mode(MODE_SPI4, 2'h0);
    mark();
    host.spi_byte(1'b1, 1'b0, 8'hA5, 4);
    expect_rx("spi4 data", 0, 1, 8'hA5);
    host.spi_byte(1'b0, 1'b0, 8'h3C, 4);
    expect_rx("spi4 cmd", 1, 0, 8'h3C);
    repeat (4) host.clk_bit(1'b1, 4);
    host.set_mode(MODE_SPI4, 2'h0);
    repeat (8) host.clk_bit(1'b0, 4);
    host.spi_byte(1'b0, 1'b0, 8'h81, 4);
    expect_rx("spi4 partial", 1, 0, 8'h81);
    host.set_mode(MODE_NONE, 2'h0);
    host.spi_byte(1'b0, 1'b0, 8'h81, 4);
    expect_rx("no port", 0, 0, 8'h00);
  endtask

  task automatic spi3Test();
    logic [7:0] rb;
    logic gone;
    host.set_mode(MODE_SPI3, 2'h0);
    mark();
    host.spi_byte(1'b1, 1'b0, 8'h2F, 4);
    expect_rx("spi3 cmd", 1, 0, 8'h2F);
    dataCountLoad <= 1'b1;
    dataCountValue <= 8'h02;
    @(posedge clock);
    dataCountLoad <= 1'b0;
    host.spi_byte(1'b1, 1'b0, 8'h11, 4);
    host.spi_byte(1'b1, 1'b0, 8'h22, 4);
    expect_rx("spi3 data", 0, 2, 8'h22);
    host.spi_byte(1'b1, 1'b0, 8'h33, 4);
    expect_rx("spi3 back", 1, 0, 8'h33);
    for (int s = 1; s >= 0; s--)
    begin
      selfTestStatus <= 1'(s);
      host.spi_byte(1'b1, 1'b0, SELF_TEST_CMD, 24);
      host.read_back(rb, gone);
      check("readback", rb, s ? 8'hF0 : 8'h0F);
      check("readback release", {7'h0, gone}, 8'h01);
      mark();
      host.spi_byte(1'b1, 1'b0, 8'h5C, 4);
      expect_rx("after readback", 1, 0, 8'h5C);
    end
  endtask

  task automatic parTest(input logic [2:0] m);
    logic [7:0] rd;
    logic dr;
    int r0, s0, c0;
    host.set_mode(m, 2'h0);
    mark();
    host.par_xfer(1'b1, 1'b1, 1'b0, 8'h5A, rd, dr);
    expect_rx("par data", 0, 1, 8'h5A);
    host.par_xfer(1'b1, 1'b0, 1'b0, 8'hC3, rd, dr);
    expect_rx("par cmd", 1, 0, 8'hC3);
    host.par_xfer(1'b0, 1'b0, 1'b0, 8'h77, rd, dr);
    expect_rx("par idle", 0, 0, 8'h00);
    r0 = nRam;
    s0 = nStat;
    c0 = nCol;
    host.par_xfer(1'b0, 1'b0, 1'b1, 8'h00, rd, dr);
    check("idle drive", {7'h0, dr}, 8'h00);
    statusByte <= 8'h96;
    host.par_xfer(1'b1, 1'b0, 1'b1, 8'h00, rd, dr);
    check("status read", rd, 8'h96);
    ramReadData <= 8'h22;
    host.par_xfer(1'b1, 1'b1, 1'b1, 8'h00, rd, dr);
    ramReadData <= 8'h33;
    host.par_xfer(1'b1, 1'b1, 1'b1, 8'h00, rd, dr);
    check("second ram read", rd, 8'h22);
    check("read drive", {7'h0, dr}, 8'h01);
    check("ram loads", 8'(nRam - r0), 8'h02);
    check("status pulses", 8'(nStat - s0), 8'h01);
    check("read columns", 8'(nCol - c0), 8'h02);
    if (m == MODE_PENA)
    begin
      mark();
      host.cs_enable_write(1'b0, 8'h4B);
      expect_rx("select latch", 1, 0, 8'h4B);
    end
  endtask

  task automatic i2cTest();
    logic ack, okAll;
    logic [7:0] seq [6] = '{8'h00, 8'h80, 8'hAE, 8'h40, 8'h01, 8'h02};
    for (int s = 0; s < 4; s++)
    begin
      host.set_mode(MODE_I2C, 2'(s));
      mark();
      seq[0] = {5'h0F, 2'(s), 1'b0};
      okAll = 1'b1;
      host.i2c_start();
      foreach (seq[i])
      begin
        host.i2c_byte(seq[i], ack);
        okAll &= ack;
      end
      host.i2c_stop();
      check("i2c acks", {7'h0, okAll}, 8'h01);
      expect_rx("i2c frame", 1, 2, 8'h02);
      host.i2c_start();
      host.i2c_byte({5'h0E, 2'(s), 1'b0}, ack);
      host.i2c_byte(8'hC0, okAll);
      host.i2c_stop();
      check("foreign acks", {6'h0, ack, okAll}, 8'h00);
      expect_rx("foreign", 0, 0, 8'h00);
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    {rst_n, selfTestStatus, dataCountLoad} = 3'h0;
    {statusByte, ramReadData, dataCountValue} = 24'h0;
    repeat (20) @(posedge clock);
    @(negedge clock);
    check("reset enables", {6'h0, hostDataOe_n, serialDataOe_n}, 8'h03);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    spi4Test();
    spi3Test();
    parTest(MODE_PSTB);
    parTest(MODE_PENA);
    i2cTest();
    giveVerdict();
  end
endmodule
